// ---- hdl/wdt_ctrl.sv ----
// watchdog timer top: control/status register, mode logic, reset and irq
`timescale 1ns/1ps
module wdt_ctrl #(
  parameter int unsigned TICK_DIV = wdt_pkg::WDT_TICK_CYCLES
) (
  input wire logic REF_CLK, // 200 MHz bus clock
  input wire logic NRST, // synchronous reset, active low
  input wire logic [1:0] ADDR, // register address
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, cycle after RD
  input wire logic ALWAYS_ON_FUSE, // 0 = programmed
  input wire logic RESET_CAUSE_FLAG, // watchdog reset cause held outside
  input wire logic GLOBAL_IRQ_EN, // core global interrupt enable
  input wire logic IRQ_VECTOR_ACK, // core enters watchdog vector
  input wire logic WDOG_RESTART, // restart instruction executed
  output logic IRQ_REQ, // interrupt request to core
  output logic SYS_RESET // one-cycle system reset request
);
  import wdt_pkg::*;

  // ==================================================================
  // state
  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic reset_en;
    logic change_en;
    logic [2:0] change_cnt;
    logic [3:0] period;
    logic sys_reset;
    logic [7:0] rdata;
  } wdt_ctrl_s;

  wdt_ctrl_s st_q, st_d;

  logic tick;
  logic expire;
  logic reset_en_eff;
  logic irq_en_eff;
  logic ctrl_wr;
  logic [3:0] wr_period;
  wdt_mode_e mode;

  // ==================================================================
  // effective control bits
  // reset cause forces reset enable
  assign reset_en_eff = st_q.reset_en | RESET_CAUSE_FLAG | ~ALWAYS_ON_FUSE;
  assign irq_en_eff = st_q.irq_en & ALWAYS_ON_FUSE;
  // mode from enables, fuse forces reset
  assign mode = wdt_mode(ALWAYS_ON_FUSE, reset_en_eff, irq_en_eff);

  assign ctrl_wr = WR && (ADDR == WDT_CTRL_OFFSET);
  assign wr_period = {WDATA[WDT_BIT_PERIOD3], WDATA[WDT_BIT_PERIOD_HI:WDT_BIT_PERIOD_LO]};

  // ==================================================================
  // oscillator tick and time-out counter
  // oscillator rate as a tick enable
  wdt_tick_div #(
    .TICK_DIV(TICK_DIV)
  ) u_div (
    .clk(REF_CLK),
    .nrst(NRST),
    .tick(tick)
  );

  wdt_timeout_counter u_cnt (
    .clk(REF_CLK),
    .nrst(NRST),
    .tick(tick),
    .run(mode != WDT_MODE_STOP),
    .restart(WDOG_RESTART),
    .period_code(st_q.period),
    .expire(expire)
  );

  // ==================================================================
  // register updates and expiry actions
  always_comb begin
    st_d = st_q;
    st_d.sys_reset = 1'b0;

    if (st_q.change_en) begin
      if (st_q.change_cnt == 3'h1) begin
        st_d.change_en = 1'b0;
        st_d.change_cnt = 3'h0;
      end else begin
        st_d.change_cnt = st_q.change_cnt - 3'h1;
      end
    end

    if (ctrl_wr) begin
      if (WDATA[WDT_BIT_IRQ_FLAG]) begin
        st_d.irq_flag = 1'b0;
      end
      st_d.irq_en = WDATA[WDT_BIT_IRQ_EN];
      if (WDATA[WDT_BIT_RESET_EN]) begin
        st_d.reset_en = 1'b1;
      end else if (st_q.change_en) begin
        st_d.reset_en = 1'b0;
      end
      if (st_q.change_en) begin
        st_d.period = wr_period;
      end
      // writing one opens a four-cycle window
      if (WDATA[WDT_BIT_CHANGE_EN]) begin
        st_d.change_en = 1'b1;
        st_d.change_cnt = WDT_CHANGE_WINDOW;
      end
    end

    if (IRQ_VECTOR_ACK) begin
      st_d.irq_flag = 1'b0;
      if (mode == WDT_MODE_BOTH) begin
        st_d.irq_en = 1'b0;
      end
    end

    // expiry last, so a set beats any clear in the same cycle
    if (expire) begin
      unique case (mode)
        WDT_MODE_STOP: begin
        end
        WDT_MODE_IRQ: begin
          st_d.irq_flag = 1'b1;
        end
        WDT_MODE_RESET: begin
          st_d.sys_reset = 1'b1;
        end
        WDT_MODE_BOTH: begin
          if (st_q.irq_flag) begin
            st_d.sys_reset = 1'b1;
          end else begin
            st_d.irq_flag = 1'b1;
          end
        end
      endcase
    end

    // read data stands only in the cycle after RD
    st_d.rdata = 8'h00;
    if (RD && ADDR == WDT_CTRL_OFFSET) begin
      st_d.rdata[WDT_BIT_IRQ_FLAG] = st_q.irq_flag;
      st_d.rdata[WDT_BIT_IRQ_EN] = irq_en_eff;
      st_d.rdata[WDT_BIT_PERIOD3] = st_q.period[3];
      st_d.rdata[WDT_BIT_CHANGE_EN] = st_q.change_en;
      st_d.rdata[WDT_BIT_RESET_EN] = reset_en_eff;
      st_d.rdata[WDT_BIT_PERIOD_HI:WDT_BIT_PERIOD_LO] = st_q.period[2:0];
    end
  end

  // ==================================================================
  // state register
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==================================================================
  // outputs
  // request gated by enable and global enable
  assign IRQ_REQ = st_q.irq_flag & irq_en_eff & GLOBAL_IRQ_EN;
  assign SYS_RESET = st_q.sys_reset;
  assign RDATA = st_q.rdata;

  // ==================================================================
  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  logic wr_change;
  assign wr_change = ctrl_wr && WDATA[WDT_BIT_CHANGE_EN];

  chk_irq_flag_set: assert property (
    expire && (mode == WDT_MODE_IRQ) |=> st_q.irq_flag)
    else $error("flag not set on expiry in interrupt mode");

  chk_vector_clears: assert property (
    IRQ_VECTOR_ACK && !expire |=> !st_q.irq_flag)
    else $error("flag survived vector entry");

  chk_flag_w1c: assert property (
    ctrl_wr && WDATA[WDT_BIT_IRQ_FLAG] && !expire |=> !st_q.irq_flag)
    else $error("write one did not clear flag");

  chk_flag_w0_keeps: assert property (
    st_q.irq_flag && ctrl_wr && !WDATA[WDT_BIT_IRQ_FLAG] && !IRQ_VECTOR_ACK
      |=> st_q.irq_flag)
    else $error("write zero disturbed flag");

  chk_irq_gate: assert property (
    IRQ_REQ == (st_q.irq_flag && st_q.irq_en && ALWAYS_ON_FUSE && GLOBAL_IRQ_EN))
    else $error("interrupt request gating wrong");

  chk_combined_ack: assert property (
    IRQ_VECTOR_ACK && (mode == WDT_MODE_BOTH) && !ctrl_wr |=> !st_q.irq_en)
    else $error("combined mode vector did not drop irq enable");

  chk_combined_reset: assert property (
    expire && (mode == WDT_MODE_BOTH) && st_q.irq_flag |=> SYS_RESET)
    else $error("no reset on unserviced combined expiry");

  chk_combined_first: assert property (
    expire && (mode == WDT_MODE_BOTH) && !st_q.irq_flag |=> st_q.irq_flag && !SYS_RESET)
    else $error("first combined expiry misbehaved");

  chk_stop_quiet: assert property (
    mode == WDT_MODE_STOP |=> !SYS_RESET)
    else $error("reset while stopped");

  chk_fuse_reset: assert property (
    expire && !ALWAYS_ON_FUSE |=> SYS_RESET)
    else $error("fuse programmed but no reset on expiry");

  chk_guarded_clear: assert property (
    ctrl_wr && !WDATA[WDT_BIT_RESET_EN] && !st_q.change_en && st_q.reset_en
      |=> st_q.reset_en)
    else $error("reset enable cleared without change enable");

  chk_guarded_period: assert property (
    !st_q.change_en |=> st_q.period == $past(st_q.period))
    else $error("period changed without change enable");

  chk_window_open: assert property (
    wr_change |=> st_q.change_en [*4])
    else $error("change window shorter than four cycles");

  chk_window_close: assert property (
    $fell(st_q.change_en) |-> $past(wr_change, 5))
    else $error("change window closed at wrong time");

  chk_cause_forces: assert property (
    RESET_CAUSE_FLAG |-> reset_en_eff && mode != WDT_MODE_STOP && mode != WDT_MODE_IRQ)
    else $error("reset cause did not force reset enable");

  chk_fuse_lock: assert property (
    !ALWAYS_ON_FUSE |-> (mode == WDT_MODE_RESET) && !IRQ_REQ)
    else $error("fuse lock not honoured");

  // ==================================================================
  // checks on the flag, reset pulse and mode decode
  // the flag has no other setter, so a stray set would mean a broken decode
  chk_flag_only_expiry: assert property (
    !st_q.irq_flag && !(expire && (mode == WDT_MODE_IRQ || mode == WDT_MODE_BOTH))
      |=> !st_q.irq_flag)
    else $error("flag set without an interrupt-capable expiry");

  chk_reset_from_expiry: assert property (
    SYS_RESET |-> $past(expire))
    else $error("system reset without an expiry");

  chk_reset_one_cycle: assert property (
    SYS_RESET |=> !SYS_RESET)
    else $error("system reset longer than one cycle");

  chk_irq_mode_no_reset: assert property (
    expire && mode == WDT_MODE_IRQ |=> !SYS_RESET)
    else $error("reset issued in interrupt mode");

  chk_reset_mode_reset: assert property (
    expire && mode == WDT_MODE_RESET |=> SYS_RESET)
    else $error("no reset on expiry in reset mode");

  chk_stop_held: assert property (
    mode == WDT_MODE_STOP |=> !expire)
    else $error("counter expired while stopped");

  chk_fuse_keeps_flag: assert property (
    !ALWAYS_ON_FUSE && !st_q.irq_flag |=> !st_q.irq_flag)
    else $error("flag set while fuse forces reset mode");

  chk_ack_keeps_en_irq: assert property (
    IRQ_VECTOR_ACK && mode == WDT_MODE_IRQ && st_q.irq_en && !ctrl_wr |=> st_q.irq_en)
    else $error("vector entry dropped enable outside combined mode");

  chk_cause_mode: assert property (
    RESET_CAUSE_FLAG && ALWAYS_ON_FUSE
      |-> mode == (st_q.irq_en ? WDT_MODE_BOTH : WDT_MODE_RESET))
    else $error("reset cause did not select a reset mode");

  chk_no_gie_no_req: assert property (
    !GLOBAL_IRQ_EN |-> !IRQ_REQ)
    else $error("interrupt requested with global enable off");

  // ==================================================================
  // checks on the guarded fields and the change window
  chk_set_reset_en: assert property (
    ctrl_wr && WDATA[WDT_BIT_RESET_EN] |=> st_q.reset_en)
    else $error("setting reset enable was refused");

  chk_open_clear: assert property (
    ctrl_wr && st_q.change_en && !WDATA[WDT_BIT_RESET_EN] |=> !st_q.reset_en)
    else $error("reset enable not cleared inside the window");

  chk_open_period: assert property (
    ctrl_wr && st_q.change_en |=> st_q.period == $past(wr_period))
    else $error("period not taken inside the window");

  chk_window_opens_only: assert property (
    !st_q.change_en && !wr_change |=> !st_q.change_en)
    else $error("change window opened without a write");

  // ==================================================================
  // checks on the period decode and the restart
  chk_period_base: assert property (
    st_q.period == 4'h0 |-> wdt_period_last(st_q.period) == 20'h0_07FF)
    else $error("shortest period is not 2048 ticks");

  chk_period_clamp: assert property (
    st_q.period >= WDT_PERIOD_MAX_CODE |-> wdt_period_last(st_q.period) == 20'hF_FFFF)
    else $error("long or reserved code is not the longest period");

  chk_restart_quiet: assert property (
    WDOG_RESTART |=> !expire [*2])
    else $error("expiry right after a restart");

  // ==================================================================
  // checks on what software reads back
  chk_read_cause: assert property (
    RD && ADDR == WDT_CTRL_OFFSET && RESET_CAUSE_FLAG |=> RDATA[WDT_BIT_RESET_EN])
    else $error("reset enable read zero with reset cause set");

  chk_read_fuse: assert property (
    RD && ADDR == WDT_CTRL_OFFSET && !ALWAYS_ON_FUSE
      |=> RDATA[WDT_BIT_RESET_EN] && !RDATA[WDT_BIT_IRQ_EN])
    else $error("fuse lock not visible in read data");

  // main scenarios
  cov_irq_mode: cover property (expire && mode == WDT_MODE_IRQ ##1 IRQ_REQ);
  cov_combined_reset: cover property (
    expire && mode == WDT_MODE_BOTH && st_q.irq_flag ##1 SYS_RESET);
  cov_combined_ack: cover property (IRQ_VECTOR_ACK && mode == WDT_MODE_BOTH);
  cov_change_seq: cover property (
    wr_change ##[1:4] ctrl_wr && !WDATA[WDT_BIT_CHANGE_EN] && !WDATA[WDT_BIT_RESET_EN]);
  cov_fuse_reset: cover property (!ALWAYS_ON_FUSE && SYS_RESET);
endmodule

// ---- hdl/wdt_pkg.sv ----
// constants, types and helper functions shared by the watchdog timer block
// ====================================================================
package wdt_pkg;

  // ==================================================================
  // register map
  localparam logic [1:0] WDT_CTRL_OFFSET = 2'h0;
  localparam logic [7:0] WDT_CTRL_RESET = 8'h00;
  localparam int WDT_BIT_IRQ_FLAG = 7;
  localparam int WDT_BIT_IRQ_EN = 6;
  localparam int WDT_BIT_PERIOD3 = 5;
  localparam int WDT_BIT_CHANGE_EN = 4;
  localparam int WDT_BIT_RESET_EN = 3;
  localparam int WDT_BIT_PERIOD_HI = 2;
  localparam int WDT_BIT_PERIOD_LO = 0;

  // ==================================================================
  // timing
  localparam int unsigned WDT_CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned WDT_OSC_FREQ_HZ = 128_000;
  // oscillator period rounded down to whole bus clock cycles
  localparam int unsigned WDT_TICK_CYCLES = WDT_CLK_FREQ_HZ / WDT_OSC_FREQ_HZ;
  localparam int WDT_TICK_W = 12;
  localparam logic [2:0] WDT_CHANGE_WINDOW = 3'h4;
  localparam int WDT_CNT_W = 20;
  localparam logic [20:0] WDT_BASE_TIMEOUT = 21'h00_0800;
  localparam logic [3:0] WDT_PERIOD_MAX_CODE = 4'h9;

  // ==================================================================
  // operating modes, one-hot
  typedef enum logic [3:0] {
    WDT_MODE_STOP = 4'b0001,
    WDT_MODE_IRQ = 4'b0010,
    WDT_MODE_RESET = 4'b0100,
    WDT_MODE_BOTH = 4'b1000
  } wdt_mode_e;

  // last count value of a period; reserved codes clamp to the longest
  function automatic logic [WDT_CNT_W-1:0] wdt_period_last(input logic [3:0] code);
    logic [3:0] c;
    logic [20:0] span;
    c = (code > WDT_PERIOD_MAX_CODE) ? WDT_PERIOD_MAX_CODE : code;
    span = WDT_BASE_TIMEOUT << c;
    wdt_period_last = WDT_CNT_W'(span - 21'h00_0001);
  endfunction

  // fuse low means programmed and forces reset mode
  function automatic wdt_mode_e wdt_mode(input logic fuse, input logic re, input logic ie);
    if (!fuse) begin
      wdt_mode = WDT_MODE_RESET;
    end else begin
      unique case ({re, ie})
        2'b00: wdt_mode = WDT_MODE_STOP;
        2'b01: wdt_mode = WDT_MODE_IRQ;
        2'b10: wdt_mode = WDT_MODE_RESET;
        default: wdt_mode = WDT_MODE_BOTH;
      endcase
    end
  endfunction

endpackage

// ---- hdl/wdt_tick_div.sv ----
// divider turning the bus clock into the watchdog oscillator tick
`timescale 1ns/1ps
module wdt_tick_div #(
  parameter int unsigned TICK_DIV = wdt_pkg::WDT_TICK_CYCLES
) (
  input wire logic clk, // bus clock
  input wire logic nrst, // synchronous reset, active low
  output logic tick // one-cycle oscillator tick
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [WDT_TICK_W-1:0] cnt;
    logic tick;
  } wdt_div_s;

  wdt_div_s st_q, st_d;

  // ==================================================================
  // free-running divider
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == WDT_TICK_W'(TICK_DIV - 1)) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule

// ---- hdl/wdt_timeout_counter.sv ----
// time-out counter running on oscillator ticks
`timescale 1ns/1ps
module wdt_timeout_counter (
  input wire logic clk, // bus clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic tick, // oscillator tick enable
  input wire logic run, // watchdog not stopped
  input wire logic restart, // restart instruction pulse
  input wire logic [3:0] period_code, // selected period code
  output logic expire // one-cycle expiry pulse
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [WDT_CNT_W-1:0] cnt;
    logic expire;
  } wdt_cnt_s;

  wdt_cnt_s st_q, st_d;

  // ==================================================================
  // counting; >= so a shortened period expires at once rather than wrap
  always_comb begin
    st_d = st_q;
    st_d.expire = 1'b0;
    if (restart || !run) begin
      st_d.cnt = '0;
    end else if (tick) begin
      if (st_q.cnt >= wdt_period_last(period_code)) begin
        st_d.cnt = '0;
        st_d.expire = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expire = st_q.expire;

  // ==================================================================
  // checks
  // restart clears count
  chk_restart_zero: assert property (@(posedge clk) disable iff (!nrst)
    restart |=> (st_q.cnt == '0 && !st_q.expire))
    else $error("counter not zero after restart");
endmodule

// ---- tb/wdt_core_model.sv ----
// core-side model: global interrupt enable and watchdog vector entry
`timescale 1ns/1ps
module wdt_core_model (
  input wire logic clk, // bus clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic irq_req, // request from the watchdog
  input wire logic ack_on, // core takes interrupts at all
  input wire logic slow, // long vector entry latency
  input wire logic gie_on, // global enable wanted by the bench
  output logic gie, // global enable to the block
  output logic ack // one-cycle vector entry pulse
);
  logic [2:0] cnt;

  // ==================================================================
  // global enable is a plain level
  assign gie = gie_on;

  // ==================================================================
  // vector entry; a real core may take several cycles to get there
  // handler never re-arms enable
  always @(posedge clk) begin
    if (!nrst) begin
      cnt <= 3'h0;
      ack <= 1'b0;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      ack <= (cnt == 3'h1);
    end else begin
      ack <= 1'b0;
      if (irq_req && ack_on && !ack) begin
        cnt <= slow ? 3'h6 : 3'h1;
      end
    end
  end
endmodule

// ---- tb/wdt_ctrl_tb.sv ----
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
module wdt_ctrl_tb;
  import wdt_pkg::*;
  localparam int unsigned DIV = 4;
  localparam int PER0 = 2048 * DIV; // shortest time-out in bus cycles
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic fuse = 1'b1, cause = 1'b0, rst_cmd = 1'b0;
  logic ack_on = 1'b0, slow = 1'b0, gie_on = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, m = 8'h00;
  logic irq_req, sys_rst, gie, ack;
  realtime ce_t = -1000.0;
  int error_cnt = 0, total_checks = 0, n;

  always #2.5 clk = ~clk;

  wdt_ctrl #(.TICK_DIV(DIV)) u_wdt_ctrl (.REF_CLK(clk), .NRST(nrst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ALWAYS_ON_FUSE(fuse),
    .RESET_CAUSE_FLAG(cause), .GLOBAL_IRQ_EN(gie), .IRQ_VECTOR_ACK(ack),
    .WDOG_RESTART(rst_cmd), .IRQ_REQ(irq_req), .SYS_RESET(sys_rst));

  wdt_core_model u_wdt_core_model (.clk(clk), .nrst(nrst), .irq_req(irq_req),
    .ack_on(ack_on), .slow(slow), .gie_on(gie_on), .gie(gie), .ack(ack));

  // ==================================================================
  // register model; vector entry clears flag, and enable in combined mode
  always @(posedge clk) begin
    if (ack === 1'b1) begin
      if (fuse && (m[3] || cause)) m[6] = 1'b0;
      m[7] = 1'b0;
    end
  end

  // change enable is open for take times 1..4 cycles after it was written
  function automatic logic [7:0] exp_rd(input realtime t);
    logic w;
    w = (t - ce_t >= 5.0) && (t - ce_t <= 20.0);
    exp_rd = {m[7], m[6] & fuse, m[5], w, m[3] | cause | ~fuse, m[2:0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==================================================================
  // bus cycles; the model applies the write as the design should
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    logic open;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    open = ($realtime - ce_t >= 5.0) && ($realtime - ce_t <= 20.0);
    if (a == 2'h0) begin
      if (d[7]) m[7] = 1'b0;
      m[6] = d[6];
      m[3] = open ? d[3] : (m[3] | d[3]);
      if (open) {m[5], m[2:0]} = {d[5], d[2:0]};
      if (d[4]) ce_t = $realtime;
    end
  endtask

  task automatic rd_chk(input logic [1:0] a);
    logic [7:0] e;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    e = (a == 2'h0) ? exp_rd($realtime) : 8'h00;
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask

  task automatic restart;
    @(posedge clk);
    rst_cmd <= 1'b1;
    @(posedge clk);
    rst_cmd <= 1'b0;
  endtask

  // kind 0 irq request, 1 system reset, 2 vector entry; bounded wait
  task automatic wait_for(input int kind, input int hi, input logic want);
    logic hit;
    hit = 1'b0;
    n = 0;
    while (!hit && n < hi) begin
      @(posedge clk);
      #1;
      n++;
      hit = (kind == 0) ? (irq_req === 1'b1) : (kind == 1) ? (sys_rst === 1'b1) : (ack === 1'b1);
    end
    check({7'h0, hit}, {7'h0, want});
    if (hit !== want) begin
      stop_test();
    end
  endtask

  // ==================================================================
  // main sequence
  initial begin
    n = $urandom(32'h4529);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(2'h0);
    bus_wr(2'($urandom_range(3, 1)), 8'($urandom));
    rd_chk(2'($urandom_range(3, 1)));
    rd_chk(2'h0);
    // bit 3 may be set at any time, period change refused
    bus_wr(2'h0, 8'h0D);
    rd_chk(2'h0);
    bus_wr(2'h0, 8'h00);
    rd_chk(2'h0);
    // timed sequence, random codes reserved ones included
    for (int i = 0; i < 4; i++) begin
      bus_wr(2'h0, 8'h18);
      bus_wr(2'h0, 8'($urandom) & 8'h2F);
      rd_chk(2'h0);
    end
    // last open cycle and first closed one
    for (int d = 2; d < 4; d++) begin
      bus_wr(2'h0, 8'h18);
      repeat (d) @(posedge clk);
      rd_chk(2'h0);
    end
    bus_wr(2'h0, 8'h00);
    rd_chk(2'h0);
    // reset cause forces bit 3 even once the stored bit is cleared
    @(posedge clk);
    cause <= 1'b1;
    bus_wr(2'h0, 8'h18);
    bus_wr(2'h0, 8'h00);
    rd_chk(2'h0);
    @(posedge clk);
    cause <= 1'b0;
    rd_chk(2'h0);
    // programmed fuse: reset mode whatever the enables say
    @(posedge clk);
    fuse <= 1'b0;
    bus_wr(2'h0, 8'h40);
    rd_chk(2'h0);
    restart();
    wait_for(1, PER0 + 20, 1'b1);
    check(8'(n >= PER0 - 8), 8'h01);
    @(posedge clk);
    fuse <= 1'b1;
    restart();
    bus_wr(2'h0, 8'h18);
    bus_wr(2'h0, 8'h40);
    restart();
    wait_for(0, PER0 + 20, 1'b1);
    check(8'(n >= PER0 - 8 && n <= PER0 + 8), 8'h01);
    m[7] = 1'b1;
    rd_chk(2'h0);
    @(posedge clk);
    gie_on <= 1'b0;
    #1;
    check({7'h0, irq_req}, 8'h00);
    @(posedge clk);
    gie_on <= 1'b1;
    bus_wr(2'h0, 8'h40);
    rd_chk(2'h0);
    bus_wr(2'h0, 8'hC0);
    rd_chk(2'h0);
    check({7'h0, irq_req}, 8'h00);
    // restarting in time keeps the expiry away
    for (int i = 0; i < 3; i++) begin
      restart();
      wait_for(0, PER0 / 2, 1'b0);
      check({7'h0, irq_req}, 8'h00);
    end
    // combined mode left unserviced: flag first, then reset
    bus_wr(2'h0, 8'h48);
    restart();
    wait_for(0, PER0 + 20, 1'b1);
    check(8'(n >= PER0 - 8), 8'h01);
    m[7] = 1'b1;
    wait_for(1, PER0 + 20, 1'b1);
    check(8'(n >= PER0 - 16), 8'h01);
    // serviced with slow entry: flag and enable cleared together
    bus_wr(2'h0, 8'hC8);
    @(posedge clk);
    ack_on <= 1'b1;
    slow <= 1'b1;
    restart();
    wait_for(2, PER0 + 20, 1'b1);
    rd_chk(2'h0);
    stop_test();
  end
endmodule
